// ===== common/mirq_pkg.sv
// mirq_pkg: register map, field positions and types of the interrupt logic.
// assumes an apb slave with 32-bit data; registers sit in the low byte.
package mirq_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_EDGE = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_CTRL_A = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CTRL_B = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_GROUP = 12'h00c;
    localparam logic [7:0] RST_REG = 8'h00;
    // writable masks
    localparam logic [7:0] MASK_EDGE = 8'h03;
    localparam logic [7:0] MASK_CTRL_A = 8'h7f;
    localparam logic [7:0] MASK_CTRL_B = 8'hff;
    localparam logic [7:0] MASK_GROUP = 8'h55;
    // primary_irq_ctrl_a bits
    localparam int A_T0F = 6;
    localparam int A_ACF = 5;
    localparam int A_EXF = 4;
    localparam int A_T0E = 3;
    localparam int A_ACE = 2;
    localparam int A_EXE = 1;
    localparam int A_GIE = 0;
    // primary_irq_ctrl_b bits
    localparam int B_LVF = 7;
    localparam int B_MFF = 6;
    localparam int B_SIF = 5;
    localparam int B_T1F = 4;
    localparam int B_LVE = 3;
    localparam int B_MFE = 2;
    localparam int B_SIE = 1;
    localparam int B_T1E = 0;
    // grouped_irq_ctrl bits
    localparam int G_EEF = 6;
    localparam int G_ADF = 4;
    localparam int G_EEE = 2;
    localparam int G_ADE = 0;
    // edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // source request strobes from internal peripherals
    typedef struct packed {
        logic timer0;
        logic timer1;
        logic auto_conv;
        logic serial_if;
        logic low_volt;
        logic eeprom;
        logic adc;
    } mirq_src_t;
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } mirq_apb_req_t;
    // service vector: one code per source, highest priority first
    typedef enum logic [3:0] {
        VEC_NONE = 4'h0,
        VEC_EXT = 4'h1,
        VEC_T0 = 4'h2,
        VEC_ACC = 4'h3,
        VEC_T1 = 4'h4,
        VEC_SIM = 4'h5,
        VEC_LVD = 4'h6,
        VEC_EE = 4'h7,
        VEC_AD = 4'h8
    } mirq_vec_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SERVICE = 2'b01
    } mirq_state_t;
endpackage : mirq_pkg

// ===== core/mirq_core.sv
// mirq_core: flags, enables, edge detector and service request of the
// microcontroller interrupt logic, with an apb register slave.
// assumes source strobes are one-cycle pulses on clk; ext pin is async.
`timescale 1ns/1ps
module mirq_core
    import mirq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire mirq_pkg::mirq_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources
    input wire logic ext_pin,
    input wire mirq_pkg::mirq_src_t src,
    // cpu side
    input wire logic service_ack,
    output logic suspend_main,
    output mirq_pkg::mirq_vec_t service_vec
);
    import mirq_pkg::*;

    logic [7:0] external_edge_config;
    logic [7:0] primary_irq_ctrl_a;
    logic [7:0] primary_irq_ctrl_b;
    logic [7:0] grouped_irq_ctrl;
    logic [2:0] pin_sync;
    logic pin_level;
    logic ext_event;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] wdata;
    logic hit_edge;
    logic hit_a;
    logic hit_b;
    logic hit_g;
    logic grp_pending;
    mirq_vec_t next_vec;
    mirq_state_t state;
    mirq_vec_t taken;

    // merge a register write with hardware sets; set wins over clear
    function automatic logic [7:0] reg_update(
        input logic [7:0] cur,
        input logic wr,
        input logic [7:0] wd,
        input logic [7:0] mask,
        input logic [7:0] hw_set,
        input logic [7:0] hw_clr
    );
        logic [7:0] v;
        v = wr ? (wd & mask) : cur;
        v = v & ~hw_clr;
        return (v | hw_set) & mask;
    endfunction : reg_update

    // apb decode; zero wait state, every access completes at once
    assign wr_stb = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_stb = apb_req.psel & ~apb_req.pwrite;
    assign wdata = apb_req.pwdata[7:0];
    assign hit_edge = apb_req.paddr == OFF_EDGE;
    assign hit_a = apb_req.paddr == OFF_CTRL_A;
    assign hit_b = apb_req.paddr == OFF_CTRL_B;
    assign hit_g = apb_req.paddr == OFF_GROUP;
    assign pready = 1'b1;
    assign pslverr = apb_req.psel & apb_req.penable
        & ~(hit_edge | hit_a | hit_b | hit_g);

    always_ff @(posedge clk)
    begin
        if (rst)
            prdata <= '0;
        else if (rd_stb & ~apb_req.penable)
        begin
            prdata <= '0;
            if (hit_edge)
                prdata[7:0] <= external_edge_config & MASK_EDGE;
            else if (hit_a)
                prdata[7:0] <= primary_irq_ctrl_a & MASK_CTRL_A;
            else if (hit_b)
                prdata[7:0] <= primary_irq_ctrl_b;
            else if (hit_g)
                prdata[7:0] <= grouped_irq_ctrl & MASK_GROUP;
        end
    end

    // three-stage pin sync; stage 0 feeds stage 1 only
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_sync <= 3'h0;
            pin_level <= 1'b0;
        end
        else
        begin
            pin_sync <= {pin_sync[1:0], ext_pin};
            if (pin_sync[1] == pin_sync[2])
                pin_level <= pin_sync[2];
        end
    end

    // edge detect on the agreed level
    always_comb
    begin
        case (external_edge_config[1:0])
            EDGE_RISE: ext_event = pin_sync[2] & pin_sync[1] & ~pin_level;
            EDGE_FALL: ext_event = ~pin_sync[2] & ~pin_sync[1] & pin_level;
            EDGE_BOTH: ext_event = (pin_sync[2] == pin_sync[1])
                & (pin_sync[2] != pin_level);
            default: ext_event = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            external_edge_config <= RST_REG;
        else
            external_edge_config <= reg_update(external_edge_config,
                wr_stb & hit_edge, wdata, MASK_EDGE, 8'h00, 8'h00);
    end

    // acknowledge clears the serviced flag, hardware sets still win
    logic [7:0] set_a;
    logic [7:0] clr_a;
    logic [7:0] set_b;
    logic [7:0] clr_b;
    logic [7:0] set_g;
    logic [7:0] clr_g;
    logic ack_now;
    assign ack_now = (state == ST_SERVICE) & service_ack;
    always_comb
    begin
        set_a = '0;
        clr_a = '0;
        set_b = '0;
        clr_b = '0;
        set_g = '0;
        clr_g = '0;
        set_a[A_T0F] = src.timer0;
        set_a[A_ACF] = src.auto_conv;
        set_a[A_EXF] = ext_event;
        set_b[B_LVF] = src.low_volt;
        set_b[B_SIF] = src.serial_if;
        set_b[B_T1F] = src.timer1;
        set_b[B_MFF] = grp_pending;
        set_g[G_EEF] = src.eeprom;
        set_g[G_ADF] = src.adc;
        if (ack_now)
        begin
            clr_a[A_EXF] = taken == VEC_EXT;
            clr_a[A_T0F] = taken == VEC_T0;
            clr_a[A_ACF] = taken == VEC_ACC;
            clr_b[B_T1F] = taken == VEC_T1;
            clr_b[B_SIF] = taken == VEC_SIM;
            clr_b[B_LVF] = taken == VEC_LVD;
            clr_g[G_EEF] = taken == VEC_EE;
            clr_g[G_ADF] = taken == VEC_AD;
        end
    end

    // grouped flag is set by any enabled pending sub-request
    assign grp_pending = (grouped_irq_ctrl[G_EEF] & grouped_irq_ctrl[G_EEE])
        | (grouped_irq_ctrl[G_ADF] & grouped_irq_ctrl[G_ADE]);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            primary_irq_ctrl_a <= RST_REG;
            primary_irq_ctrl_b <= RST_REG;
            grouped_irq_ctrl <= RST_REG;
        end
        else
        begin
            primary_irq_ctrl_a <= reg_update(primary_irq_ctrl_a,
                wr_stb & hit_a, wdata, MASK_CTRL_A, set_a, clr_a);
            primary_irq_ctrl_b <= reg_update(primary_irq_ctrl_b,
                wr_stb & hit_b, wdata, MASK_CTRL_B, set_b, clr_b);
            grouped_irq_ctrl <= reg_update(grouped_irq_ctrl,
                wr_stb & hit_g, wdata, MASK_GROUP, set_g, clr_g);
        end
    end

    // fixed priority pick among serviceable sources
    always_comb
    begin
        next_vec = VEC_NONE;
        if (primary_irq_ctrl_a[A_GIE])
        begin
            if (primary_irq_ctrl_a[A_EXF] & primary_irq_ctrl_a[A_EXE])
                next_vec = VEC_EXT;
            else if (primary_irq_ctrl_a[A_T0F] & primary_irq_ctrl_a[A_T0E])
                next_vec = VEC_T0;
            else if (primary_irq_ctrl_a[A_ACF] & primary_irq_ctrl_a[A_ACE])
                next_vec = VEC_ACC;
            else if (primary_irq_ctrl_b[B_T1F] & primary_irq_ctrl_b[B_T1E])
                next_vec = VEC_T1;
            else if (primary_irq_ctrl_b[B_SIF] & primary_irq_ctrl_b[B_SIE])
                next_vec = VEC_SIM;
            else if (primary_irq_ctrl_b[B_LVF] & primary_irq_ctrl_b[B_LVE])
                next_vec = VEC_LVD;
            else if (primary_irq_ctrl_b[B_MFF] & primary_irq_ctrl_b[B_MFE])
            begin
                if (grouped_irq_ctrl[G_EEF] & grouped_irq_ctrl[G_EEE])
                    next_vec = VEC_EE;
                else if (grouped_irq_ctrl[G_ADF] & grouped_irq_ctrl[G_ADE])
                    next_vec = VEC_AD;
            end
        end
    end

    // service sequencer; one request held until the cpu acknowledges
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_RUN;
            taken <= VEC_NONE;
        end
        else
        begin
            case (state)
                ST_RUN:
                    if (next_vec != VEC_NONE)
                    begin
                        state <= ST_SERVICE;
                        taken <= next_vec;
                    end
                ST_SERVICE:
                    if (service_ack)
                    begin
                        state <= ST_RUN;
                        taken <= VEC_NONE;
                    end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

    assign suspend_main = state == ST_SERVICE;
    assign service_vec = taken;

    a_edge_masked: assert property (@(posedge clk) disable iff (rst)
        external_edge_config[7:2] == 6'h00)
        else $error("edge register upper bits not zero");
    a_ext_off: assert property (@(posedge clk) disable iff (rst)
        external_edge_config[1:0] == EDGE_OFF |-> !ext_event)
        else $error("ext event while detection off");
    a_rise_flag: assert property (@(posedge clk) disable iff (rst)
        ext_event |=> primary_irq_ctrl_a[A_EXF])
        else $error("ext flag not set by edge");
    a_a_bit7: assert property (@(posedge clk) disable iff (rst)
        !primary_irq_ctrl_a[7])
        else $error("register a bit 7 set");
    a_group_odd: assert property (@(posedge clk) disable iff (rst)
        (grouped_irq_ctrl & ~MASK_GROUP) == 8'h00)
        else $error("grouped odd bits set");
    a_mff_follow: assert property (@(posedge clk) disable iff (rst)
        grp_pending |=> primary_irq_ctrl_b[B_MFF])
        else $error("grouped flag not raised");
    a_gie_gate: assert property (@(posedge clk) disable iff (rst)
        $rose(suspend_main) |-> $past(primary_irq_ctrl_a[A_GIE]))
        else $error("service without global enable");
    a_service_hold: assert property (@(posedge clk) disable iff (rst)
        suspend_main && !service_ack |=> suspend_main)
        else $error("service dropped before ack");
    // checked one edge after each reset cycle; the first edge sees unknowns
    a_reset_zero: assert property (@(posedge clk)
        rst |=> primary_irq_ctrl_a == 8'h00 && primary_irq_ctrl_b == 8'h00
        && grouped_irq_ctrl == 8'h00
        && external_edge_config == 8'h00)
        else $error("registers not zero after reset");
    a_vec_hold: assert property (@(posedge clk) disable iff (rst)
        suspend_main && !service_ack |=> $stable(service_vec))
        else $error("service vector changed before ack");
    a_t1_flag: assert property (@(posedge clk) disable iff (rst)
        src.timer1 |=> primary_irq_ctrl_b[B_T1F])
        else $error("timer1 flag not set");
    c_ext_service: cover property (@(posedge clk) disable iff (rst)
        ext_event ##[1:4] (service_vec == VEC_EXT));
    c_grouped: cover property (@(posedge clk) disable iff (rst)
        service_vec == VEC_AD);
    c_ack: cover property (@(posedge clk) disable iff (rst)
        suspend_main ##1 service_ack ##1 !suspend_main);
endmodule : mirq_core

// ===== tb/mirq_src_model.sv
// mirq_src_model: far side of the interrupt logic, the pin and peripherals.
// assumes the bench asks for pulses and pin levels one cycle ahead.
`timescale 1ns/1ps
module mirq_src_model
    import mirq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench requests
    input wire mirq_pkg::mirq_src_t pulse_req,
    input wire logic ext_lvl,
    // toward the block
    output mirq_pkg::mirq_src_t src,
    output logic ext_pin
);
    // peripherals strobe for exactly one cycle per event
    always_ff @(posedge clk)
    begin
        if (rst)
            src <= '0;
        else
            src <= pulse_req;
    end

    // the pin is driven from a flop, so it never glitches mid-cycle
    always_ff @(posedge clk)
    begin
        ext_pin <= ext_lvl;
    end
endmodule : mirq_src_model

// ===== tb/tb_mcu_interrupt_request_logic.sv
// tb_mcu_interrupt_request_logic: self-checking bench of mirq_core.
// assumes the zero-wait apb slave and the source model beside it.
`timescale 1ns/1ps
module tb_mcu_interrupt_request_logic;
    import mirq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mirq_apb_req_t apb_req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, suspend_main, ext_pin;
    logic service_ack = 1'b0;
    logic ext_lvl = 1'b0;
    logic in_svc = 1'b0;
    mirq_vec_t service_vec;
    mirq_src_t pulse_req = '0;
    mirq_src_t src;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'h03a0;
    logic [7:0] v;
    logic [32:0] rd_q[$];
    mirq_vec_t vec_q[$];
    localparam logic [6:0] ST[7] = '{7'h40, 7'h10, 7'h20, 7'h08, 7'h04,
        7'h02, 7'h01};
    localparam logic [7:0] AT[7] = '{8'h09, 8'h05, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01};
    localparam logic [7:0] BT[7] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h08,
        8'h04, 8'h04};
    localparam logic [7:0] GT[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h04, 8'h01};
    localparam mirq_vec_t VT[7] = '{VEC_T0, VEC_ACC, VEC_T1, VEC_SIM,
        VEC_LVD, VEC_EE, VEC_AD};

    always #5 clk = ~clk;

    mirq_core u_dut (.clk(clk), .rst(rst), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_pin(ext_pin), .src(src), .service_ack(service_ack),
        .suspend_main(suspend_main), .service_vec(service_vec));
    mirq_src_model u_src (.clk(clk), .rst(rst), .pulse_req(pulse_req),
        .ext_lvl(ext_lvl), .src(src), .ext_pin(ext_pin));

    task stop_test;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task cmp_rd(input logic [32:0] e, input logic [32:0] s);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("BAD read exp %h got %h", e, s);
        end
    endtask : cmp_rd

    task cmp_vec(input mirq_vec_t e, input mirq_vec_t s);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("BAD service_vec exp %h got %h", e, s);
        end
    endtask : cmp_vec

    // request held from setup until pready is sampled high
    task apb_xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        r = $random(seed);
        @(posedge clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.paddr <= a;
        apb_req.pwrite <= w;
        apb_req.pwdata <= {r[31:8], d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb_xfer

    task apb_rd(input logic [11:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb_xfer(1'b0, a, 8'h00);
    endtask : apb_rd

    task pulse(input logic [6:0] m);
        @(posedge clk);
        pulse_req <= mirq_src_t'(m);
        @(posedge clk);
        pulse_req <= '0;
    endtask : pulse

    task clear_all;
        apb_xfer(1'b1, OFF_GROUP, 8'h00);
        apb_xfer(1'b1, OFF_CTRL_B, 8'h00);
        apb_xfer(1'b1, OFF_CTRL_A, 8'h00);
        apb_xfer(1'b1, OFF_EDGE, 8'h00);
    endtask : clear_all

    // watcher: reads and service entries are matched to the oldest note
    always @(posedge clk)
    begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite
            && pready === 1'b1 && rd_q.size() > 0)
            cmp_rd(rd_q.pop_front(), {pslverr, prdata});
        if (suspend_main === 1'b1 && !in_svc)
        begin
            in_svc <= 1'b1;
            service_ack <= 1'b1;
            if (vec_q.size() == 0)
                cmp_vec(VEC_NONE, service_vec);
            else
                cmp_vec(vec_q.pop_front(), service_vec);
        end
        else
            service_ack <= 1'b0;
        if (suspend_main === 1'b0)
            in_svc <= 1'b0;
    end

    // whole run is about 540 cycles; this is a generous ceiling
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            apb_rd(12'(i * 4), 33'h0);
        apb_rd(12'h010, {1'b1, 32'h0});
        $display("test reset done");
        v = 8'($random(seed));
        apb_xfer(1'b1, OFF_EDGE, v);
        apb_rd(OFF_EDGE, {25'h0, v & MASK_EDGE});
        v = 8'($random(seed)) & 8'hfe;
        apb_xfer(1'b1, OFF_CTRL_A, v);
        apb_rd(OFF_CTRL_A, {25'h0, v & MASK_CTRL_A});
        v = 8'($random(seed));
        apb_xfer(1'b1, OFF_CTRL_B, v);
        apb_rd(OFF_CTRL_B, {25'h0, v});
        v = 8'($random(seed));
        apb_xfer(1'b1, OFF_GROUP, v);
        apb_rd(OFF_GROUP, {25'h0, v & MASK_GROUP});
        clear_all();
        $display("test masks done");
        apb_xfer(1'b1, OFF_CTRL_A, 8'h01);
        pulse(7'h40);
        repeat (4) @(posedge clk);
        apb_rd(OFF_CTRL_A, 33'h41);
        vec_q.push_back(VEC_T0);
        apb_xfer(1'b1, OFF_CTRL_A, 8'h49);
        repeat (10) @(posedge clk);
        apb_rd(OFF_CTRL_A, 33'h09);
        // global enable still on: a grouped request without mfe must wait
        apb_xfer(1'b1, OFF_GROUP, 8'h04);
        pulse(7'h02);
        repeat (4) @(posedge clk);
        apb_rd(OFF_CTRL_B, 33'h40);
        apb_rd(OFF_GROUP, 33'h44);
        clear_all();
        $display("test blocked done");
        for (int k = 0; k < 7; k++)
        begin
            vec_q.push_back(VT[k]);
            apb_xfer(1'b1, OFF_CTRL_A, AT[k]);
            apb_xfer(1'b1, OFF_CTRL_B, BT[k]);
            apb_xfer(1'b1, OFF_GROUP, GT[k]);
            pulse(ST[k]);
            repeat (10) @(posedge clk);
            clear_all();
        end
        $display("test sources done");
        for (int m = 0; m < 4; m++)
        begin
            apb_xfer(1'b1, OFF_EDGE, 8'(m));
            apb_xfer(1'b1, OFF_CTRL_A, 8'h03);
            if (m[0])
                vec_q.push_back(VEC_EXT);
            ext_lvl <= 1'b1;
            repeat (15) @(posedge clk);
            if (m[1])
                vec_q.push_back(VEC_EXT);
            ext_lvl <= 1'b0;
            repeat (15) @(posedge clk);
            clear_all();
        end
        $display("test edges done");
        repeat (5) @(posedge clk);
        if (vec_q.size() != 0 || rd_q.size() != 0)
            failures++;
        stop_test();
    end
endmodule : tb_mcu_interrupt_request_logic
